/* common/rss_pkg.sv */
// Notes on behaviour
// [R1] Pin cause set after 67/4163 low cycles.
// [R2] Held-low reset pin halts all processing.
// [R3] Internal causes drive pin low 32 cycles.
// [R4] Internal reset holds 32 cycles after release.
// [R5] Power-on/low-voltage drive pin 4096+32 cycles.
// [R6] Power-on: clocks held off 4096 cycles.
// [R7] Power-on sets its flag, clears others.
// [R8] Watchdog overflow resets and sets flag.
// [R9] Service write clears watchdog, prescale bits 12:5.
// [R10] 13-bit prescale on oscillator falling edge.
// [R11] Watchdog disabled only by test-voltage combinations.
// [R12] Watchdog reset input is asynchronous.
// [R13] Illegal opcode sets flag and resets.
// [R14] Stop with stop disabled is illegal opcode.
// [R15] Only unmapped opcode fetches cause address reset.
// [R16] Low voltage: flag, long drive, late release.
// [R17] Monitor-entry input causes internal reset.
// [R18] Stop instruction clears the prescale counter.
// [R19] Stop recovery waits 4096 or 32 oscillator cycles.
// [R20] Pin reset leaves prescale alone; free running.
// [R21] Interrupt entry saves and masks; return restores.
// [R22] Every reset gives vector FFFE, monitor FEFE.
// [R23] Internal reset clears prescale, external does not.
// [R24] Reset pin and watchdog input double synchronised.
package rss_pkg;

	// ==========================================================
	// Timing counts in internal clock cycles; stop recovery counts are in oscillator cycles.
	localparam logic [12:0] PIN_LOW_CYCLES    = 13'h0043;
	localparam logic [12:0] POR_PIN_CYCLES    = 13'h1043;
	localparam logic [12:0] DRIVE_CYCLES      = 13'h0020;
	localparam logic [12:0] POR_DRIVE_CYCLES  = 13'h1020;
	localparam logic [12:0] HOLD_CYCLES       = 13'h0020;
	localparam logic [12:0] OSC_STAB_CYCLES   = 13'h1000;
	localparam logic [12:0] STOP_LONG_CYCLES  = 13'h1000;
	localparam logic [12:0] STOP_SHORT_CYCLES = 13'h0020;

	// ==========================================================
	// Counter layout.
	localparam int          PRESCALE_BITS  = 13;
	localparam int          SERVICE_LO_BIT = 5;
	localparam int          WDOG_BITS      = 6;
	localparam logic [15:0] SERVICE_ADDR   = 16'hFFFF;
	localparam logic [15:0] VECTOR_USER    = 16'hFFFE;
	localparam logic [15:0] VECTOR_MONITOR = 16'hFEFE;

	// ==========================================================
	// Register map (byte addresses) and fields.
	localparam logic [7:0]  CAUSE_ADDR   = 8'h00;
	localparam logic [7:0]  CTRL_ADDR    = 8'h04;
	localparam logic [7:0]  SVC_ADDR     = 8'h08;
	localparam logic [7:0]  STATUS_ADDR  = 8'h0C;
	localparam int          CAUSE_POR    = 6;
	localparam int          CAUSE_PIN    = 5;
	localparam int          CAUSE_WDOG   = 4;
	localparam int          CAUSE_ILLEGAL_OPCODE_FLAG   = 3;
	localparam int          CAUSE_ILLEGAL_ADDRESS_FLAG   = 2;
	localparam int          CAUSE_MON    = 1;
	localparam int          CAUSE_LVD    = 0;
	localparam logic [6:0]  CAUSE_RESET  = 7'h40;
	localparam int          CTRL_STOPEN  = 0;
	localparam int          CTRL_SHORT   = 1;
	localparam int          CTRL_MONITOR = 2;
	localparam int          CTRL_BREAK   = 3;
	localparam logic [3:0]  CTRL_RESET   = 4'h0;
	localparam int          ST_WDOG_LO   = 16;
	localparam int          ST_PHASE_LO  = 24;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [2:0] {
		PH_RUN,
		PH_PIN,
		PH_DRIVE,
		PH_HOLD,
		PH_STOP,
		PH_RECOVER
	} phase_t;

	typedef struct packed {
		logic        illegal_opcode;
		logic        stop_instr;
		logic        opcode_fetch;
		logic        unmapped_addr;
		logic        wake;
		logic        int_entry;
		logic        int_return;
		logic        write;
		logic [15:0] addr;
	} cpu_events_t;

	typedef struct packed {
		logic save_regs;
		logic set_mask;
		logic restore_regs;
	} cpu_actions_t;

endpackage

/* hdl/reset_source_sequencer.sv */
`timescale 1ns/1ps
module reset_source_sequencer
	import rss_pkg::*;
#(
	parameter logic [12:0] POR_DRIVE_LEN = POR_DRIVE_CYCLES,
	parameter logic [12:0] POR_PIN_LEN   = POR_PIN_CYCLES
)(
	// Clock and reset.
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	// Reset pin and asynchronous sources.
	input  wire logic         rst_pin_i,
	output logic              rst_pin_o,
	output logic              rst_pin_oe_n_o,
	input  wire logic         power_on_pulse_i,
	input  wire logic         low_voltage_i,
	input  wire logic         watchdog_reset_i,
	input  wire logic         monitor_entry_reset_i,
	input  wire logic         selected_osc_clock_i,
	input  wire logic         rst_high_voltage_i,
	input  wire logic         interrupt_line_one_high_voltage_i,
	// CPU side.
	input  wire cpu_events_t  cpu_i,
	output cpu_actions_t      cpu_o,
	output logic              internal_reset_o,
	output logic              internal_bus_clocks_o,
	output logic              clock_generator_output_o,
	output logic [15:0]       reset_vector_o,
	// AXI4-Lite slave.
	input  wire logic         s_axi_awvalid_i,
	output logic              s_axi_awready_o,
	input  wire logic [7:0]   s_axi_awaddr_i,
	input  wire logic         s_axi_wvalid_i,
	output logic              s_axi_wready_o,
	input  wire logic [31:0]  s_axi_wdata_i,
	input  wire logic [3:0]   s_axi_wstrb_i,
	output logic              s_axi_bvalid_o,
	input  wire logic         s_axi_bready_i,
	output logic [1:0]        s_axi_bresp_o,
	input  wire logic         s_axi_arvalid_i,
	output logic              s_axi_arready_o,
	input  wire logic [7:0]   s_axi_araddr_i,
	output logic              s_axi_rvalid_o,
	input  wire logic         s_axi_rready_i,
	output logic [31:0]       s_axi_rdata_o,
	output logic [1:0]        s_axi_rresp_o
);

	// ==========================================================
	// State.
	typedef struct packed {
		phase_t                    phase;
		logic                      long_seq;
		logic [12:0]               seq_cnt;
		logic [12:0]               pin_cnt;
		logic [PRESCALE_BITS-1:0]  prescale;
		logic [WDOG_BITS-1:0]      wdog;
		logic [6:0]                cause;
		logic [3:0]                ctrl;
		logic [1:0]                pin_s;
		logic [1:0]                por_s;
		logic [1:0]                lvd_s;
		logic [1:0]                wdr_s;
		logic [1:0]                mon_s;
		logic [1:0]                rhv_s;
		logic [1:0]                ihv_s;
		logic [1:0]                osc_s;
		logic                      osc_d;
		logic                      aw_got;
		logic [7:0]                aw_addr;
		logic                      w_got;
		logic [31:0]               w_data;
		logic                      w_lane0;
		logic                      bvalid;
		logic [1:0]                bresp;
		logic                      rvalid;
		logic [31:0]               rdata;
		logic [1:0]                rresp;
		cpu_actions_t              act;
	} state_t;

	state_t s;
	state_t next_s;

	// ==========================================================
	// Helpers.
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == CAUSE_ADDR) || (a == CTRL_ADDR) || (a == SVC_ADDR)
			|| (a == STATUS_ADDR);
	endfunction

	function automatic state_t reset_value();
		state_t r;
		r          = '0;
		r.phase    = PH_DRIVE;
		r.long_seq = 1'b1;
		r.cause    = CAUSE_RESET;
		r.ctrl     = CTRL_RESET;
		r.pin_s    = 2'h3;
		r.osc_s    = 2'h0;
		r.osc_d    = 1'b0;
		r.rhv_s    = 2'h0;
		return r;
	endfunction

	logic       pin_low;
	logic       osc_fall;
	logic       wdog_off;
	logic       wdog_ovf;
	logic       service;
	logic       do_write;
	logic [6:0] cause_set;
	logic       start_int;
	logic       start_long;
	logic       running;
	logic [12:0] drive_len;
	logic [12:0] pin_len;
	logic [12:0] stop_len;

	always_comb
	begin
		next_s = s;
		// Two-stage synchronisers for every asynchronous input.
		// [R24] Synchronise pin inputs.
		next_s.pin_s = {s.pin_s[0], rst_pin_i};
		next_s.por_s = {s.por_s[0], power_on_pulse_i};
		next_s.lvd_s = {s.lvd_s[0], low_voltage_i};
		// [R12] Asynchronous watchdog input.
		next_s.wdr_s = {s.wdr_s[0], watchdog_reset_i};
		next_s.mon_s = {s.mon_s[0], monitor_entry_reset_i};
		next_s.rhv_s = {s.rhv_s[0], rst_high_voltage_i};
		next_s.ihv_s = {s.ihv_s[0], interrupt_line_one_high_voltage_i};
		next_s.osc_s = {s.osc_s[0], selected_osc_clock_i};
		next_s.osc_d = s.osc_s[1];
		next_s.act   = '0;

		pin_low  = ~s.pin_s[1];
		// [R10] Falling oscillator edge.
		osc_fall = s.osc_d & ~s.osc_s[1];
		running  = (s.phase == PH_RUN);
		// [R11] Combinational watchdog disable.
		wdog_off = (s.ctrl[CTRL_MONITOR] & (s.rhv_s[1] | s.ihv_s[1]))
			| (s.ctrl[CTRL_BREAK] & s.rhv_s[1]);
		drive_len = s.long_seq ? POR_DRIVE_LEN : DRIVE_CYCLES;
		pin_len   = s.long_seq ? POR_PIN_LEN : PIN_LOW_CYCLES;
		stop_len  = s.ctrl[CTRL_SHORT] ? STOP_SHORT_CYCLES : STOP_LONG_CYCLES;

		// ==========================================================
		// Register bus.
		do_write = s.aw_got & s.w_got & ~s.bvalid;
		if (s_axi_awvalid_i && !s.aw_got && !s.bvalid)
		begin
			next_s.aw_got  = 1'b1;
			next_s.aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && !s.w_got && !s.bvalid)
		begin
			next_s.w_got   = 1'b1;
			next_s.w_data  = s_axi_wdata_i;
			next_s.w_lane0 = s_axi_wstrb_i[0];
		end
		if (do_write)
		begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if (s.aw_addr == CTRL_ADDR && s.w_lane0)
			begin
				next_s.ctrl = s.w_data[3:0];
			end
		end
		if (s.bvalid && s_axi_bready_i)
		begin
			next_s.bvalid = 1'b0;
		end
		if (s_axi_arvalid_i && !s.rvalid)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
			next_s.rdata  = 32'h0000_0000;
			unique case (s_axi_araddr_i)
				CAUSE_ADDR:  next_s.rdata[6:0] = s.cause;
				CTRL_ADDR:   next_s.rdata[3:0] = s.ctrl;
				STATUS_ADDR:
				begin
					next_s.rdata[PRESCALE_BITS-1:0] = s.prescale;
					next_s.rdata[ST_WDOG_LO +: WDOG_BITS] = s.wdog;
					next_s.rdata[ST_PHASE_LO +: 3] = s.phase;
				end
				default:     next_s.rdata = 32'h0000_0000;
			endcase
		end
		else if (s.rvalid && s_axi_rready_i)
		begin
			next_s.rvalid = 1'b0;
		end

		// ==========================================================
		// Prescale and watchdog.
		// [R9] Service write clears counters.
		service = (cpu_i.write && cpu_i.addr == SERVICE_ADDR)
			|| (do_write && s.aw_addr == SVC_ADDR);
		// [R20] Prescale free running.
		if (osc_fall && s.phase != PH_STOP)
		begin
			next_s.prescale = s.prescale + 13'h0001;
		end
		wdog_ovf = 1'b0;
		// [R10] Overflow clocks watchdog.
		if (osc_fall && s.phase != PH_STOP && &s.prescale && running && !wdog_off)
		begin
			next_s.wdog = s.wdog + 6'h01;
			wdog_ovf    = &s.wdog;
		end
		if (service)
		begin
			next_s.wdog = '0;
			next_s.prescale[PRESCALE_BITS-1:SERVICE_LO_BIT] = '0;
		end

		// ==========================================================
		// Reset causes.
		cause_set  = '0;
		start_long = s.por_s[1] | s.lvd_s[1];
		// [R16] Low-voltage flag.
		cause_set[CAUSE_LVD] = s.lvd_s[1] & ~s.por_s[1];
		start_int = 1'b0;
		if (running || s.phase == PH_STOP || s.phase == PH_RECOVER)
		begin
			// [R8] Watchdog timeout reset.
			cause_set[CAUSE_WDOG] = (wdog_ovf | s.wdr_s[1]) & ~wdog_off;
			// [R13] Illegal opcode reset.
			// [R14] Disabled stop is illegal.
			cause_set[CAUSE_ILLEGAL_OPCODE_FLAG] = running & (cpu_i.illegal_opcode
				| (cpu_i.stop_instr & ~s.ctrl[CTRL_STOPEN]));
			// [R15] Opcode fetches only.
			cause_set[CAUSE_ILLEGAL_ADDRESS_FLAG] = running & cpu_i.opcode_fetch & cpu_i.unmapped_addr;
			// [R17] Monitor entry reset.
			cause_set[CAUSE_MON]  = s.mon_s[1];
			start_int = |cause_set;
		end

		// [R1] Pin held long enough.
		if (pin_low)
		begin
			if (s.pin_cnt != 13'h1FFF)
			begin
				next_s.pin_cnt = s.pin_cnt + 13'h0001;
			end
			if (s.pin_cnt == pin_len - 13'h0001)
			begin
				cause_set[CAUSE_PIN] = 1'b1;
			end
		end
		else
		begin
			next_s.pin_cnt = '0;
		end

		// Hardware set wins over a software clear of the same bit.
		if (do_write && s.aw_addr == CAUSE_ADDR && s.w_lane0)
		begin
			next_s.cause = s.cause & ~s.w_data[6:0];
		end
		next_s.cause = next_s.cause | cause_set;
		// [R7] Power-on clears other flags.
		if (s.por_s[1])
		begin
			next_s.cause = CAUSE_RESET;
		end

		// ==========================================================
		// Sequencer.
		unique case (s.phase)
			PH_RUN:
			begin
				// [R2] Low pin halts processing.
				if (pin_low)
				begin
					next_s.phase = PH_PIN;
				end
				else if (cpu_i.stop_instr && s.ctrl[CTRL_STOPEN])
				begin
					next_s.phase = PH_STOP;
					// [R18] Stop clears prescale.
					next_s.prescale = '0;
				end
			end
			PH_PIN:
			begin
				if (!pin_low)
				begin
					next_s.phase   = PH_HOLD;
					next_s.seq_cnt = '0;
				end
			end
			PH_DRIVE:
			begin
				// [R3] Drive pin for set length.
				next_s.seq_cnt = s.seq_cnt + 13'h0001;
				if (s.seq_cnt == drive_len - 13'h0001)
				begin
					next_s.phase   = PH_HOLD;
					next_s.seq_cnt = '0;
				end
			end
			PH_HOLD:
			begin
				// [R4] Internal reset extends.
				next_s.seq_cnt = s.seq_cnt + 13'h0001;
				if (s.seq_cnt == HOLD_CYCLES - 13'h0001)
				begin
					next_s.phase    = pin_low ? PH_PIN : PH_RUN;
					next_s.long_seq = 1'b0;
				end
			end
			PH_STOP:
			begin
				if (cpu_i.wake)
				begin
					next_s.phase = PH_RECOVER;
				end
			end
			PH_RECOVER:
			begin
				// [R19] Stop recovery delay.
				if (s.prescale >= stop_len)
				begin
					next_s.phase = PH_RUN;
				end
			end
		endcase

		// [R2] Pin reset ends stop.
		if (pin_low && (s.phase == PH_STOP || s.phase == PH_RECOVER))
		begin
			next_s.phase = PH_PIN;
		end

		// [R23] Internal reset clears prescale.
		if (start_long || start_int)
		begin
			next_s.phase    = PH_DRIVE;
			next_s.seq_cnt  = '0;
			next_s.prescale = '0;
			next_s.wdog     = '0;
			// [R5] Long drive for power-on/low-voltage.
			next_s.long_seq = start_long;
		end

		// [R21] Interrupt entry and return.
		if (running)
		begin
			next_s.act.save_regs    = cpu_i.int_entry;
			next_s.act.set_mask     = cpu_i.int_entry;
			next_s.act.restore_regs = cpu_i.int_return;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			s <= reset_value();
		end
		else
		begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs.
	assign rst_pin_o        = 1'b0;
	assign rst_pin_oe_n_o   = (s.phase != PH_DRIVE);
	assign internal_reset_o = (s.phase == PH_PIN) || (s.phase == PH_DRIVE)
		|| (s.phase == PH_HOLD);
	// [R6] Clocks held off while oscillator settles.
	assign internal_bus_clocks_o = (s.phase != PH_STOP) && (s.phase != PH_RECOVER)
		&& !(s.phase == PH_DRIVE && s.long_seq && s.seq_cnt < OSC_STAB_CYCLES);
	assign clock_generator_output_o = (s.phase != PH_STOP);
	// [R22] Reset vector select.
	assign reset_vector_o  = s.ctrl[CTRL_MONITOR] ? VECTOR_MONITOR : VECTOR_USER;
	assign cpu_o           = s.act;
	assign s_axi_awready_o = ~s.aw_got & ~s.bvalid;
	assign s_axi_wready_o  = ~s.w_got & ~s.bvalid;
	assign s_axi_bvalid_o  = s.bvalid;
	assign s_axi_bresp_o   = s.bresp;
	assign s_axi_arready_o = ~s.rvalid;
	assign s_axi_rvalid_o  = s.rvalid;
	assign s_axi_rdata_o   = s.rdata;
	assign s_axi_rresp_o   = s.rresp;

endmodule

/* tb/reset_source_sequencer_chk.sv */
`timescale 1ns/1ps
// ====================================
// Port checker for the reset sequencer.
module reset_source_sequencer_chk
	import rss_pkg::*;
(
	input wire logic         clk_i,
	input wire logic         sys_rst_i,
	input wire logic         rst_pin_i,
	input wire logic         rst_pin_oe_n_o,
	input wire logic         monitor_entry_reset_i,
	input wire cpu_events_t  cpu_i,
	input wire cpu_actions_t cpu_o,
	input wire logic         internal_reset_o,
	input wire logic         internal_bus_clocks_o,
	input wire logic         clock_generator_output_o
);
	logic run;

	assign run = !internal_reset_o && internal_bus_clocks_o && clock_generator_output_o;

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	chk_drive_internal_reset: assert property (!rst_pin_oe_n_o |-> internal_reset_o)
		else $error("internal reset low while pin driven");
	chk_hold_internal_reset: assert property ($rose(rst_pin_oe_n_o) |-> internal_reset_o [*8])
		else $error("internal reset ended early after pin release");
	chk_por_drive: assert property ($fell(sys_rst_i) |-> !rst_pin_oe_n_o [*8])
		else $error("pin not driven after power-on");
	chk_illegal_opcode_flag_reset: assert property (run && cpu_i.illegal_opcode |-> ##[1:3] !rst_pin_oe_n_o)
		else $error("illegal opcode gave no pin drive");
	chk_data_fetch: assert property (run && cpu_i.unmapped_addr && !cpu_i.opcode_fetch
		&& !cpu_i.illegal_opcode && !cpu_i.stop_instr |-> ##1 rst_pin_oe_n_o [*3])
		else $error("data fetch caused a reset");
	chk_monitor_rst: assert property (run && monitor_entry_reset_i |-> ##[1:5] !rst_pin_oe_n_o)
		else $error("monitor entry gave no pin drive");
	chk_pin_halt: assert property (!rst_pin_i [*6] |-> internal_reset_o)
		else $error("processing not halted by low pin");
	chk_int_entry: assert property (run && cpu_i.int_entry |=> cpu_o.save_regs && cpu_o.set_mask)
		else $error("interrupt entry actions missing");
	chk_int_return: assert property (run && cpu_i.int_return |=> cpu_o.restore_regs)
		else $error("interrupt return action missing");

	cover property (run && cpu_i.illegal_opcode);
	cover property ($rose(rst_pin_oe_n_o));
	cover property (!clock_generator_output_o);
endmodule

bind reset_source_sequencer reset_source_sequencer_chk reset_source_sequencer_chk_inst (.*);

/* tb/reset_source_sequencer_tb.sv */
`timescale 1ns/1ps
// ====================================
// Self-checking bench for the reset sequencer.
module reset_source_sequencer_tb;
	import rss_pkg::*;

	typedef struct packed {
		logic [3:0] ctrl;
		logic [1:0] hv;
		logic [2:0] src;
		logic [3:0] ev;
		logic [6:0] cause;
	} row_t;

	logic clk_i = 1'b0, sys_rst_i = 1'b1, osc = 1'b0, pin, oe_n, internal_reset, busclk, cgen, pull_go = 1'b0;
	logic [7:0] pull_len = 8'h00, awaddr = 8'h00, araddr = 8'h00;
	logic [1:0] hv = 2'h0, bresp, rresp, r;
	logic [2:0] src = 3'h0;
	logic [15:0] vec;
	logic [31:0] wdata = 32'h00000000, rdata, d;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	cpu_events_t cpu = '0;
	cpu_events_t e;
	logic por = 1'b0, pdrv;
	cpu_actions_t act;
	int failures = 0, cmp_count = 0;
	row_t rows [10];

	always #2.5 clk_i = ~clk_i;

	rss_pin_model rss_pin_model_inst (.clk_i(clk_i), .pull_len_i(pull_len), .pull_go_i(pull_go),
		.rst_pin_oe_n_i(oe_n), .rst_pin_o(pin));

	reset_source_sequencer #(.POR_DRIVE_LEN(13'h0028), .POR_PIN_LEN(13'h004B))
	reset_source_sequencer_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rst_pin_i(pin),
		.rst_pin_o(pdrv), .rst_pin_oe_n_o(oe_n), .power_on_pulse_i(por), .low_voltage_i(src[0]),
		.watchdog_reset_i(src[2]), .monitor_entry_reset_i(src[1]),
		.selected_osc_clock_i(osc), .rst_high_voltage_i(hv[0]), .interrupt_line_one_high_voltage_i(hv[1]),
		.cpu_i(cpu), .cpu_o(act), .internal_reset_o(internal_reset), .internal_bus_clocks_o(busclk),
		.clock_generator_output_o(cgen), .reset_vector_o(vec),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp));

	// ====================================
	// Bus, compare and closing tasks.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (arready === 1'b1) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	task automatic wait_run;
		int n;
		n = 0;
		repeat (8) @(posedge clk_i);
		while (!(internal_reset === 1'b0 && busclk === 1'b1 && oe_n === 1'b1) && n < 600)
		begin
			@(posedge clk_i);
			n++;
		end
		chk("run wait", 32'h00000000, {31'h0, n >= 600});
	endtask

	task automatic osc_run(input int n);
		repeat (n)
		begin
			osc <= 1'b1;
			repeat (4) @(posedge clk_i);
			osc <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
	endtask

	task automatic pulse(input cpu_events_t e);
		cpu <= e;
		@(posedge clk_i);
		cpu <= '0;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic end_of_test;
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		#100us;
		failures++;
		end_of_test();
	end

	// ====================================
	// Main sequence.
	initial
	begin
		rows = '{'{4'h0, 2'h0, 3'h0, 4'h8, 7'h08}, '{4'h0, 2'h0, 3'h0, 4'h4, 7'h08},
			'{4'h0, 2'h0, 3'h0, 4'h3, 7'h04}, '{4'h0, 2'h0, 3'h0, 4'h1, 7'h00},
			'{4'h0, 2'h0, 3'h4, 4'h0, 7'h10}, '{4'h0, 2'h0, 3'h2, 4'h0, 7'h02},
			'{4'h0, 2'h0, 3'h1, 4'h0, 7'h01}, '{4'h4, 2'h1, 3'h4, 4'h0, 7'h00},
			'{4'h4, 2'h2, 3'h4, 4'h0, 7'h00}, '{4'h8, 2'h1, 3'h4, 4'h0, 7'h00}};
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		axi_rd(CAUSE_ADDR, d, r);
		chk("por cause", 32'h00000040, d);
		wait_run();
		$display("power-on test done");
		foreach (rows[i])
		begin
			axi_wr(CTRL_ADDR, {28'h0000000, rows[i].ctrl});
			axi_wr(CAUSE_ADDR, 32'h0000007F);
			hv <= rows[i].hv;
			repeat (4) @(posedge clk_i);
			e = '0;
			{e.illegal_opcode, e.stop_instr, e.opcode_fetch, e.unmapped_addr} = rows[i].ev;
			src <= rows[i].src;
			pulse(e);
			repeat (2) @(posedge clk_i);
			src <= 3'h0;
			wait_run();
			axi_rd(CAUSE_ADDR, d, r);
			chk("cause", {25'h0, rows[i].cause}, d);
			hv <= 2'h0;
			$display("row %0d done", i);
		end
		osc_run(40);
		axi_rd(STATUS_ADDR, d, r);
		chk("prescale", 32'h00000028, d & 32'h00001FFF);
		axi_wr(CAUSE_ADDR, 32'h0000007F);
		pull_len <= 8'h48;
		pull_go <= 1'b1;
		@(posedge clk_i);
		pull_go <= 1'b0;
		wait_run();
		axi_rd(CAUSE_ADDR, d, r);
		chk("pin cause", 32'h00000020, d);
		axi_rd(STATUS_ADDR, d, r);
		chk("prescale kept", 32'h00000028, d & 32'h00001FFF);
		pulse('{write: 1'b1, addr: SERVICE_ADDR, default: '0});
		axi_rd(STATUS_ADDR, d, r);
		chk("serviced", 32'h00000008, d & 32'h003F1FFF);
		pulse('{illegal_opcode: 1'b1, default: '0});
		wait_run();
		axi_rd(STATUS_ADDR, d, r);
		chk("prescale cleared", 32'h00000000, d & 32'h00001FFF);
		$display("prescale tests done");
		axi_wr(CTRL_ADDR, 32'h00000003);
		osc_run(5);
		pulse('{stop_instr: 1'b1, default: '0});
		chk("clock gen", 32'h00000000, {31'h0, cgen});
		axi_rd(STATUS_ADDR, d, r);
		chk("stop prescale", 32'h00000000, d & 32'h00001FFF);
		pulse('{wake: 1'b1, default: '0});
		osc_run(31);
		chk("bus clocks", 32'h00000000, {31'h0, busclk});
		osc_run(2);
		chk("bus clocks", 32'h00000001, {31'h0, busclk});
		pulse('{int_entry: 1'b1, default: '0});
		pulse('{int_return: 1'b1, default: '0});
		$display("stop test done");
		axi_wr(CTRL_ADDR, 32'h00000004);
		axi_rd(CTRL_ADDR, d, r);
		chk("ctrl", 32'h00000004, d);
		chk("vector", {16'h0000, VECTOR_MONITOR}, {16'h0000, vec});
		axi_wr(CTRL_ADDR, 32'h00000000);
		@(posedge clk_i);
		chk("vector", {16'h0000, VECTOR_USER}, {16'h0000, vec});
		axi_rd(8'h10, d, r);
		chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		$display("register test done");
		por <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk("por bus clocks", 32'h00000000, {31'h0, busclk});
		chk("por clock gen", 32'h00000001, {31'h0, cgen});
		chk("por pin drive", 32'h00000000, {30'h0, oe_n, pdrv});
		por <= 1'b0;
		wait_run();
		axi_rd(CAUSE_ADDR, d, r);
		chk("por clears", 32'h00000040, d);
		$display("power-on pulse test done");
		end_of_test();
	end
endmodule

/* tb/rss_pin_model.sv */
`timescale 1ns/1ps
// ====================================
// Peripheral sharing the open-drain reset line.
module rss_pin_model (
	// Clock and request.
	input  wire logic       clk_i,
	input  wire logic [7:0] pull_len_i,
	input  wire logic       pull_go_i,
	// Reset line.
	input  wire logic       rst_pin_oe_n_i,
	output logic            rst_pin_o
);
	logic [7:0] left;

	initial left = 8'h00;

	always @(posedge clk_i)
		if (pull_go_i)
			left <= pull_len_i;
		else if (left != 8'h00)
			left <= left - 8'h01;

	assign rst_pin_o = !(left != 8'h00 || !rst_pin_oe_n_i);
endmodule
